// >>> hdl/switcher_fault_sequencer.sv
// Functional notes
// R01 - Peak-limit flag assertion starts the 55 ms fault timer.
// R02 - Flag still set at timer end: stop pulses, stay off eight periods (440 ms).
// R03 - After off phase retry for 55 ms; repeat while fault persists (~11% burst).
// R04 - Fault gone during a retry: resume normal switching.
// R05 - Fault and off durations come from internal timing only.
// R06 - Each start ramps peak setpoint to maximum in about 1.0 ms.
// R07 - Peak-limit flag set whenever setpoint reaches its maximum.
// R08 - Pulses enabled only after supply reaches turn-on level.
// R09 - Startup source turns off when supply reaches turn-on level.
// R10 - Supply below minimum cuts pulses at once, over the fault timer.
// R11 - Mains low input blocks switching; resume when back in range.
// R12 - Latch input above its level latches the part off until supply cycles.
// R13 - Startup source gives reduced current below 1.3 V, nominal above.
// R14 - Light load skips unneeded switching cycles.
// R15 - Switching clock gets a low-frequency jitter modulation.
// R16 - Over-power input lowers max setpoint, down to 20% of maximum.
// R17 - Skip threshold is 25 percent of maximum peak setpoint.
// R18 - Jitter swings the frequency about plus or minus 6 percent.
// R19 - Latch input is integrated over about 20 us before latching.
// R20 - Current-sense trip ignored for 200 ns blanking after turn-on.
// R21 - Fault, off and soft-start timing counted on oscillator periods.
// R22 - Latch and all counters cleared only by the lockout reset; the code also clears fault_cnt, off_cnt and ramp in the sequencer.
//
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/100ps
`default_nettype none
module switcher_fault_sequencer #(
  parameter int OSC_PERIOD = switcher_pkg::OSC_PERIOD_CYC,
  parameter int FAULT_TICKS = switcher_pkg::FAULT_TICKS,
  parameter int LATCH_CYC = switcher_pkg::LATCH_CYC
) (
  // Clock and undervoltage lockout reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Comparator decisions
  input wire logic vcc_on_i,
  input wire logic vcc_min_ok_i,
  input wire logic vcc_above_th_i,
  input wire logic mains_low_input_i,
  input wire logic latch_level_i,
  input wire logic cs_trip_i,
  input wire logic [7:0] fb_demand_i,
  input wire logic [7:0] over_power_reduction_i,
  // Power stage controls
  output logic drive_o,
  output logic startup_en_o,
  output logic startup_current_second_o,
  output logic [7:0] setpoint_o,
  output logic peak_flag_o,
  output logic latched_o,
  // AXI4-Lite slave
  input wire logic [3:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [3:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i
);

  localparam int CW = switcher_pkg::CW;
  localparam logic [CW-1:0] DMAX_CYC = CW'(OSC_PERIOD * switcher_pkg::DMAX_PCT / 100);
  localparam logic [CW-1:0] PERIOD_NOM = CW'(OSC_PERIOD);
  localparam logic [CW-1:0] FAULT_LAST = CW'(FAULT_TICKS - 1);
  localparam logic [CW-1:0] LATCH_LAST = CW'(LATCH_CYC);
  // Span tracks the period parameter, so a shortened period cannot wrap below zero
  localparam logic [CW-1:0] JIT_SPAN = CW'(OSC_PERIOD * switcher_pkg::JIT_PCT / 100);
  localparam logic [CW-1:0] TRI_TOP = JIT_SPAN << 1;

  typedef struct packed {
    switcher_pkg::seq_state_t st;
    logic [CW-1:0] phase, period, tri_pos, on_cnt, fault_cnt, latch_filt;
    logic tri_up, fault_run, drive, peak_flag, startup_en, startup_high, latched;
    logic [2:0] off_cnt;
    logic [7:0] ramp, setpoint, bursts;
    logic [1:0] ctrl;
    logic awready, wready, aw_held, w_held, bvalid, arready, rvalid;
    logic [3:0] awaddr;
    logic [1:0] wbits;
    logic wlane0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } state_t;

  state_t s, next_s;
  logic [7:0] maxsp, limit;
  logic tick, can_sw, skip;
  logic [3:0] rsel, wsel;

  // One-hot register select; an unmapped address gives all zeros
  function automatic logic [3:0] reg_sel(input logic [3:0] a);
    reg_sel = {a == switcher_pkg::TIMER_OFS, a == switcher_pkg::SETPT_OFS,
               a == switcher_pkg::STATUS_OFS, a == switcher_pkg::CTRL_OFS};
  endfunction : reg_sel

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    next_s = s;
    // Over-power lowers the ceiling but never below the floor
    if (over_power_reduction_i >= switcher_pkg::SP_MAX - switcher_pkg::OPP_FLOOR) begin // [R16]
      maxsp = switcher_pkg::OPP_FLOOR;
    end else begin
      maxsp = switcher_pkg::SP_MAX - over_power_reduction_i;
    end
    limit = (s.ramp < maxsp) ? s.ramp : maxsp;
    tick = (s.phase >= s.period - 16'h0001);
    // Lockout and mains checks gate pulses directly, not via the timer
    can_sw = (s.st == switcher_pkg::ST_RUN) && !mains_low_input_i && vcc_min_ok_i // [R10] [R11]
             && s.ctrl[switcher_pkg::CTRL_EN_BIT];
    skip = fb_demand_i < switcher_pkg::SKIP_LEVEL; // [R14] [R17]
    rsel = reg_sel(araddr_i);
    wsel = reg_sel(s.awaddr);

    // Oscillator with triangular period modulation
    next_s.phase = tick ? '0 : s.phase + 16'h0001;
    if (tick) begin
      if (s.tri_up) begin // [R18]
        if (s.tri_pos + switcher_pkg::JIT_STEP >= TRI_TOP) begin
          next_s.tri_pos = TRI_TOP;
          next_s.tri_up = 1'b0;
        end else begin
          next_s.tri_pos = s.tri_pos + switcher_pkg::JIT_STEP;
        end
      end else if (s.tri_pos <= switcher_pkg::JIT_STEP) begin
        next_s.tri_pos = '0;
        next_s.tri_up = 1'b1;
      end else begin
        next_s.tri_pos = s.tri_pos - switcher_pkg::JIT_STEP;
      end
      if (s.ctrl[switcher_pkg::CTRL_JIT_BIT]) begin
        next_s.period = PERIOD_NOM - JIT_SPAN + s.tri_pos; // [R15]
      end else begin
        next_s.period = PERIOD_NOM;
      end
    end

    // Switch pulse: start on tick, end on trip after blanking or at max duty
    if (s.drive) begin
      next_s.on_cnt = s.on_cnt + 16'h0001;
      if ((s.on_cnt >= switcher_pkg::LEB_CYC && cs_trip_i) || s.on_cnt >= DMAX_CYC - 16'h0001) begin // [R20]
        next_s.drive = 1'b0;
      end
    end
    if (tick && can_sw && !skip) begin // [R08] [R14]
      next_s.drive = 1'b1;
      next_s.on_cnt = '0;
    end
    if (!can_sw) begin
      next_s.drive = 1'b0; // [R10] [R11]
    end

    // Setpoint, soft-start ramp and peak-limit flag
    if (s.st == switcher_pkg::ST_RUN) begin
      if (tick) begin // [R06] [R21]
        next_s.ramp = (s.ramp > switcher_pkg::SP_MAX - switcher_pkg::SS_STEP) ?
                      switcher_pkg::SP_MAX : s.ramp + switcher_pkg::SS_STEP;
      end
      next_s.setpoint = (fb_demand_i < limit) ? fb_demand_i : limit;
      next_s.peak_flag = fb_demand_i >= limit; // [R07]
    end else begin
      next_s.ramp = '0; // Every start begins a fresh ramp
      next_s.setpoint = '0;
      next_s.peak_flag = 1'b0;
    end

    // Startup source: current level follows the 1.3 V comparator
    next_s.startup_high = vcc_above_th_i; // [R13]
    if (!vcc_min_ok_i) begin
      next_s.startup_en = 1'b1;
    end else if (vcc_on_i) begin
      next_s.startup_en = 1'b0; // [R09]
    end

    // Protection sequencer
    unique case (s.st)
      switcher_pkg::ST_CHARGE: begin
        if (vcc_on_i && !mains_low_input_i) begin // [R08] [R11]
          next_s.st = switcher_pkg::ST_RUN;
          next_s.fault_run = 1'b0;
          next_s.fault_cnt = '0;
        end
      end
      switcher_pkg::ST_RUN: begin
        if (!vcc_min_ok_i || mains_low_input_i) begin // [R10] [R11]
          next_s.st = switcher_pkg::ST_CHARGE;
        end else if (tick) begin
          // Timer counts oscillator periods, never the supply ramp
          if (s.fault_run) begin // [R05] [R21]
            if (s.fault_cnt == FAULT_LAST) begin
              next_s.fault_run = 1'b0;
              next_s.fault_cnt = '0;
              // Fault cleared in time means we simply keep switching
              if (s.peak_flag) begin // [R02] [R04]
                next_s.st = switcher_pkg::ST_OFF;
                next_s.off_cnt = '0;
                next_s.bursts = s.bursts + 8'h01;
                next_s.drive = 1'b0;
              end
            end else begin
              next_s.fault_cnt = s.fault_cnt + 16'h0001;
            end
          end else if (s.peak_flag) begin // [R01]
            next_s.fault_run = 1'b1;
            next_s.fault_cnt = '0;
          end
        end
      end
      switcher_pkg::ST_OFF: begin
        if (tick) begin // [R02] [R21]
          if (s.fault_cnt == FAULT_LAST) begin
            next_s.fault_cnt = '0;
            next_s.off_cnt = s.off_cnt + 3'h1;
            if (s.off_cnt == switcher_pkg::OFF_LAST) begin
              next_s.st = switcher_pkg::ST_RUN; // [R03]
            end
          end else begin
            next_s.fault_cnt = s.fault_cnt + 16'h0001;
          end
        end
      end
      switcher_pkg::ST_LATCH: begin
        next_s.drive = 1'b0; // [R12] [R22]
      end
    endcase

    // Latch input integrator: leaky up/down count filters surges
    if (latch_level_i) begin // [R19]
      if (s.latch_filt != LATCH_LAST) begin
        next_s.latch_filt = s.latch_filt + 16'h0001;
      end
    end else if (s.latch_filt != '0) begin
      next_s.latch_filt = s.latch_filt - 16'h0001;
    end
    if (s.latch_filt == LATCH_LAST) begin
      next_s.st = switcher_pkg::ST_LATCH; // [R12]
      next_s.drive = 1'b0;
    end
    // Registered copy keeps the latch output straight off a flop
    next_s.latched = (next_s.st == switcher_pkg::ST_LATCH);

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken in either order
    if (awvalid_i && s.awready) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = awaddr_i;
    end
    if (wvalid_i && s.wready) begin
      next_s.w_held = 1'b1;
      next_s.wbits = wdata_i[1:0];
      next_s.wlane0 = wstrb_i[0];
    end
    if (s.bvalid && bready_i) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = (wsel == 4'h0) ? switcher_pkg::RESP_SLVERR : switcher_pkg::RESP_OKAY;
      if (wsel[0] && s.wlane0) begin
        next_s.ctrl = s.wbits;
      end
    end
    next_s.awready = !next_s.aw_held && !next_s.bvalid;
    next_s.wready = !next_s.w_held && !next_s.bvalid;

    // AXI4-Lite read
    if (s.rvalid && rready_i) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid_i && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = (rsel == 4'h0) ? switcher_pkg::RESP_SLVERR : switcher_pkg::RESP_OKAY;
      next_s.rdata = '0;
      if (rsel[0]) next_s.rdata = {30'h0, s.ctrl};
      if (rsel[1]) next_s.rdata = {16'h0, s.bursts, 1'b0, s.off_cnt, s.fault_run, s.peak_flag, s.st};
      if (rsel[2]) next_s.rdata = {16'h0, s.ramp, s.setpoint};
      if (rsel[3]) next_s.rdata = {16'h0, s.fault_cnt};
    end
    next_s.arready = !next_s.rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset is the supply lockout, the only way out of latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin // [R22]
      s <= '0;
      s.period <= PERIOD_NOM;
      s.tri_up <= 1'b1;
      s.ctrl <= switcher_pkg::CTRL_RST;
      s.startup_en <= 1'b1;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign drive_o = s.drive;
  assign startup_en_o = s.startup_en;
  assign startup_current_second_o = s.startup_high;
  assign setpoint_o = s.setpoint;
  assign peak_flag_o = s.peak_flag;
  assign latched_o = s.latched;
  assign awready_o = s.awready;
  assign wready_o = s.wready;
  assign bresp_o = s.bresp;
  assign bvalid_o = s.bvalid;
  assign arready_o = s.arready;
  assign rdata_o = s.rdata;
  assign rresp_o = s.rresp;
  assign rvalid_o = s.rvalid;

endmodule : switcher_fault_sequencer
`default_nettype wire

// >>> hdl/switcher_pkg.sv
`default_nettype none
package switcher_pkg;
  // Widths
  localparam int CW = 16;
  localparam int SP_W = 8;
  // Clock and oscillator
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 65_000;
  localparam int OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;
  localparam int JIT_PCT = 6;
  localparam logic [CW-1:0] JIT_SPAN = CW'(OSC_PERIOD_CYC * JIT_PCT / 100);
  localparam logic [CW-1:0] JIT_STEP = 16'h0002;
  localparam int DMAX_PCT = 80;
  // Protection timing, counted in oscillator periods
  localparam int FAULT_MS = 55;
  localparam int FAULT_TICKS = FAULT_MS * OSC_HZ / 1000;
  localparam int OFF_MS = 440;
  localparam logic [2:0] OFF_LAST = 3'(OFF_MS / FAULT_MS - 1);
  localparam int SS_US = 1000;
  localparam int SS_TICKS = (SS_US * (OSC_HZ / 1000) + 999) / 1000;
  // Timing counted in clock cycles
  localparam int LEB_NS = 200;
  localparam logic [CW-1:0] LEB_CYC = CW'((LEB_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam int LATCH_US = 20;
  localparam int LATCH_CYC = LATCH_US * (CLK_HZ / 1_000_000);
  // Peak setpoint scale
  localparam logic [SP_W-1:0] SP_MAX = 8'hff;
  localparam logic [SP_W-1:0] SS_STEP = SP_W'((int'(SP_MAX) + SS_TICKS - 1) / SS_TICKS);
  localparam int SKIP_PCT = 25;
  localparam logic [SP_W-1:0] SKIP_LEVEL = SP_W'(int'(SP_MAX) * SKIP_PCT / 100);
  localparam int OPP_MIN_PCT = 20;
  localparam logic [SP_W-1:0] OPP_FLOOR = SP_W'(int'(SP_MAX) * OPP_MIN_PCT / 100);
  // Register map
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam logic [3:0] SETPT_OFS = 4'h8;
  localparam logic [3:0] TIMER_OFS = 4'hc;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_JIT_BIT = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Sequencer states
  typedef enum logic [1:0] {ST_CHARGE, ST_RUN, ST_OFF, ST_LATCH} seq_state_t;
endpackage : switcher_pkg
`default_nettype wire

// >>> verif/switcher_properties.sv
`timescale 1ns/100ps
`default_nettype none
module switcher_props (
  // Clock and lockout reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Comparator inputs
  input wire logic vcc_on_i,
  input wire logic vcc_min_ok_i,
  input wire logic vcc_above_th_i,
  input wire logic mains_low_input_i,
  input wire logic latch_level_i,
  input wire logic [7:0] fb_demand_i,
  input wire logic [7:0] over_power_reduction_i,
  // Power stage outputs
  input wire logic drive_o,
  input wire logic startup_en_o,
  input wire logic startup_current_second_o,
  input wire logic [7:0] setpoint_o,
  input wire logic latched_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // No cut pending, so a fresh pulse must still be high 7 cycles after it rises
  wire logic live = vcc_min_ok_i & ~mains_low_input_i & ~latch_level_i;
  ////////////////////////////////////////////////////////////////
  undervoltage_lockout_cut_a: assert property (!vcc_min_ok_i |=> !drive_o) else $error("drive after lockout");
  mains_block_a: assert property (mains_low_input_i |=> !drive_o) else $error("drive at low mains");
  latch_keep_a: assert property (latched_o |=> latched_o) else $error("latch released");
  latch_stop_a: assert property (latched_o |=> !drive_o) else $error("drive while latched");
  startup_off_a: assert property (vcc_on_i && vcc_min_ok_i |=> !startup_en_o) else $error("source stays on");
  startup_on_a: assert property (!vcc_min_ok_i |=> startup_en_o) else $error("source not on");
  level_track_a: assert property (!$past(rst_i) |-> startup_current_second_o == $past(vcc_above_th_i))
    else $error("startup level wrong");
  // Pulses only start at or above the skip level; the setpoint obeys demand and the over-power cap
  skip_low_a: assert property ($rose(drive_o) |-> $past(fb_demand_i) >= 8'h3f)
    else $error("pulse below skip");
  opp_cap_a: assert property (setpoint_o <= $past(fb_demand_i) && setpoint_o <=
    (($past(over_power_reduction_i) > 8'hcc) ? 8'h33 : 8'hff - $past(over_power_reduction_i)))
    else $error("setpoint above cap");
  blank_hold_a: assert property (($rose(drive_o) && live) ##1 live [*7] |-> drive_o)
    else $error("pulse cut in blanking");
  // Main scenarios reached
  cover property ($rose(drive_o));
  cover property ($rose(latched_o));
  cover property ($rose(setpoint_o == 8'hff));
endmodule : switcher_props
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
  logic clk_i = 0, rst_i = 1, vcc_on_i = 0, vcc_min_ok_i = 0, vcc_above_th_i = 0;
  logic mains_low_input_i = 0, latch_level_i = 0, cs_trip_i = 0;
  logic [7:0] fb_demand_i = 0, over_power_reduction_i = 0, setpoint_o;
  logic drive_o, startup_en_o, startup_current_second_o, peak_flag_o, latched_o;
  logic [3:0] awaddr_i = 0, wstrb_i = 4'hf, araddr_i = 0;
  logic awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0, rready_i = 0;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic [31:0] wdata_i = 0, rdata_o, lfsr = 32'hbc5f;
  logic [1:0] bresp_o, rresp_o;
  logic [33:0] exp_q[$], msk_q[$];
  int err_count = 0, num_checks = 0, cyc = 0, drv_cnt = 0;
  // Short counts keep the fault and off phases within the run
  switcher_fault_sequencer #(.OSC_PERIOD(40), .FAULT_TICKS(80), .LATCH_CYC(8)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .vcc_on_i(vcc_on_i), .vcc_min_ok_i(vcc_min_ok_i),
    .vcc_above_th_i(vcc_above_th_i), .mains_low_input_i(mains_low_input_i), .latch_level_i(latch_level_i),
    .cs_trip_i(cs_trip_i), .fb_demand_i(fb_demand_i), .over_power_reduction_i(over_power_reduction_i),
    .drive_o(drive_o), .startup_en_o(startup_en_o), .startup_current_second_o(startup_current_second_o),
    .setpoint_o(setpoint_o), .peak_flag_o(peak_flag_o), .latched_o(latched_o),
    .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
    .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o), .bresp_o(bresp_o),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
    .rready_i(rready_i)
  );
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Random current trips, pulse cycle count and hang guard
  always @(posedge clk_i) begin
    lfsr <= lfsr_next(lfsr);
    cs_trip_i <= lfsr[3] & lfsr[7];
    cyc++;
    if (drive_o) drv_cnt++;
    if (cyc == 60000) begin
      err_count++;
      final_report();
    end
  end
  // Read results are matched against the oldest note
  always @(posedge clk_i) if (rvalid_o && rready_i) begin
    logic [33:0] e;
    logic [33:0] m;
    e = exp_q.pop_front();
    m = msk_q.pop_front();
    `CHK("read", e, {rresp_o, rdata_o} & m)
  end
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  // Address and data offered together, each released once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    bit ad;
    bit wd;
    ad = 0;
    wd = 0;
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1;
    wvalid_i <= 1;
    bready_i <= 1;
    while (!(ad && wd)) begin
      @(posedge clk_i);
      if (awvalid_i && awready_o) begin
        ad = 1;
        awvalid_i <= 0;
      end
      if (wvalid_i && wready_o) begin
        wd = 1;
        wvalid_i <= 0;
      end
    end
    do @(posedge clk_i); while (!bvalid_o);
    bready_i <= 0;
    `CHK("bresp", r, bresp_o)
    // One idle edge so a following call never re-drives bready in this time step
    @(posedge clk_i);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [33:0] e, input logic [33:0] m);
    araddr_i <= a;
    arvalid_i <= 1;
    rready_i <= 1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    do @(posedge clk_i); while (!arready_o);
    arvalid_i <= 0;
    do @(posedge clk_i); while (!rvalid_o);
    rready_i <= 0;
    @(posedge clk_i);
  endtask : rd
  // Bounded wait for the peak flag, returning the cycles spent
  task automatic wait_flag(input logic v, output int c);
    c = 0;
    while (peak_flag_o !== v && c < 40000) begin
      @(posedge clk_i);
      c++;
    end
  endtask : wait_flag
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////
  initial begin
    int c;
    int k;
    tick(20);
    rst_i <= 0;
    `CHK("drive", 1'b0, drive_o)
    `CHK("src", 1'b1, startup_en_o)
    rd(4'h0, 34'h3, '1);
    rd(4'h2, {2'h2, 32'h0}, '1);
    // Jitter off so oscillator periods are exact
    wr(4'h0, 32'h1, 2'h0);
    wr(4'h2, 32'h0, 2'h2);
    rd(4'h0, 34'h1, '1);
    done("registers");
    vcc_above_th_i <= 1;
    vcc_min_ok_i <= 1;
    fb_demand_i <= {3'h0, lfsr[4:0]};
    tick(100);
    `CHK("level", 1'b1, startup_current_second_o)
    `CHK("early", 0, drv_cnt)
    vcc_on_i <= 1;
    tick(3);
    `CHK("src", 1'b0, startup_en_o)
    rd(4'h4, 34'h1, 34'h3);
    tick(300);
    `CHK("skip", 0, drv_cnt)
    done("startup");
    mains_low_input_i <= 1;
    tick(5);
    rd(4'h4, 34'h0, 34'h3);
    mains_low_input_i <= 0;
    fb_demand_i <= 8'hc8;
    // Flag stands while the ramp clamps demand; setpoint meets demand after about 50 ticks
    wait_flag(1, c);
    `CHK("ssflag", 1'b1, 1'(c < 8))
    c = 0;
    while (setpoint_o !== 8'hc8 && c < 40000) begin
      @(posedge clk_i);
      c++;
    end
    `CHK("ramp", 1'b1, 1'(c > 1880 && c < 2120))
    `CHK("resume", 1'b1, 1'(drv_cnt > 0))
    tick(3300);
    rd(4'h4, 34'h1, 34'hff03);
    done("softstart");
    fb_demand_i <= 8'hff;
    wait_flag(1, c);
    wait_flag(0, c);
    `CHK("timer", 1'b1, 1'(c > 3190 && c < 3260))
    tick(2);
    k = drv_cnt;
    wait_flag(1, c);
    `CHK("off", 1'b1, 1'(c > 25555 && c < 25640))
    `CHK("quiet", k, drv_cnt)
    rd(4'h4, 34'h101, 34'hff03);
    fb_demand_i <= 8'h64;
    tick(3400);
    rd(4'h4, 34'h101, 34'hff03);
    k = drv_cnt;
    tick(100);
    `CHK("normal", 1'b1, 1'(drv_cnt > k))
    over_power_reduction_i <= 8'hf0;
    tick(5);
    `CHK("floor", 8'h33, setpoint_o)
    over_power_reduction_i <= lfsr[7:0];
    tick(200);
    done("burst");
    vcc_min_ok_i <= 0;
    vcc_on_i <= 0;
    tick(2);
    `CHK("cut", 1'b0, drive_o)
    `CHK("src", 1'b1, startup_en_o)
    // A short latch glitch is filtered out, a long one latches
    latch_level_i <= 1;
    tick(5);
    latch_level_i <= 0;
    tick(20);
    `CHK("glitch", 1'b0, latched_o)
    latch_level_i <= 1;
    tick(12);
    latch_level_i <= 0;
    vcc_min_ok_i <= 1;
    tick(20);
    `CHK("latch", 1'b1, latched_o)
    rd(4'h4, 34'h3, 34'h3);
    rst_i <= 1;
    tick(2);
    rst_i <= 0;
    tick(1);
    `CHK("clear", 1'b0, latched_o)
    rd(4'h0, 34'h3, '1);
    done("latch");
    final_report();
  end
endmodule : testbench
bind switcher_fault_sequencer switcher_props props_u (
  .clk_i(clk_i), .rst_i(rst_i), .vcc_on_i(vcc_on_i), .vcc_min_ok_i(vcc_min_ok_i),
  .vcc_above_th_i(vcc_above_th_i), .mains_low_input_i(mains_low_input_i), .latch_level_i(latch_level_i),
  .fb_demand_i(fb_demand_i), .over_power_reduction_i(over_power_reduction_i), .drive_o(drive_o),
  .startup_en_o(startup_en_o), .startup_current_second_o(startup_current_second_o),
  .setpoint_o(setpoint_o), .latched_o(latched_o)
);
`default_nettype wire
